/* File: rtl/fbr_reporter.v */
/*
 * fault blink code reporter: latches the first fault, flashes burst,
 * code and argument on the module-bus lamp, drives the error lamp and
 * the exception answer, and holds outputs in stop state when the latched first fault is a bus fault.
 * assumes fault inputs come from logic on clk_i; fieldbus failure and
 * watchdog expiry are pins and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fbr_consts.vh"
module fbr_reporter #(
    parameter SLOTS = 64,
    parameter FAST_HALF = `FBR_FAST_HALF,
    parameter SLOW_HALF = `FBR_SLOW_HALF,
    parameter OUT_W = 16
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // module-bus faults
    input wire bus_data_fault_i,
    input wire bus_init_fault_i,
    input wire [7:0] bus_fault_slot_i,
    input wire [SLOTS-1:0] slot_has_data_i,
    // fieldbus faults, one-cycle pulses
    input wire no_bootp_i,
    input wire not_ident_i,
    input wire bad_station_hw_identifier_i,
    input wire tcpip_init_err_i,
    // processor traps, one-cycle pulses
    input wire trap_opcode_i,
    input wire trap_stack_ovf_i,
    input wire trap_stack_unf_i,
    input wire trap_nmi_i,
    // fieldbus status pins
    input wire fieldbus_fail_i,
    input wire watchdog_on_i,
    input wire watchdog_expired_i,
    // modbus request
    input wire req_valid_i,
    output wire exc_valid_o,
    output reg [15:0] exc_code_o,
    // process outputs
    input wire [OUT_W-1:0] proc_data_i,
    input wire [OUT_W-1:0] stop_state_i,
    output reg [OUT_W-1:0] node_out_o,
    // lamps
    output reg bus_lamp_red_o,
    output reg err_lamp_o,
    // fault report
    output reg fault_active_o,
    output reg [3:0] fault_code_o,
    output reg [7:0] fault_arg_o
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    reg [2:0] fb_sync_ff;
    reg [2:0] wd_sync_ff;
    reg fb_ff;
    reg wd_ff;
    reg wd_latch_ff;
    wire wd_seen = wd_ff | wd_latch_ff;

    always @(posedge clk_i) begin
        if (rst_i) begin
            fb_sync_ff <= 3'h0;
            fb_ff <= 1'b0;
        end else begin
            fb_sync_ff <= {fb_sync_ff[1:0], fieldbus_fail_i};
            if (fb_sync_ff[2] == fb_sync_ff[1]) begin
                fb_ff <= fb_sync_ff[2];
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wd_sync_ff <= 3'h0;
            wd_ff <= 1'b0;
        end else begin
            wd_sync_ff <= {wd_sync_ff[1:0],
                           watchdog_on_i & watchdog_expired_i};
            if (wd_sync_ff[2] == wd_sync_ff[1]) begin
                wd_ff <= wd_sync_ff[2];
            end
        end
    end

    // ************************************************************
    // error lamp and exception answer
    // ************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            err_lamp_o <= 1'b0;
            wd_latch_ff <= 1'b0;
            exc_code_o <= 16'h0000;
        end else begin
            err_lamp_o <= fb_ff;
            if (wd_ff) begin
                wd_latch_ff <= 1'b1;
            end
            exc_code_o <= wd_seen ?
                `FBR_EXC_DEV_FAIL : 16'h0000;
        end
    end

    assign exc_valid_o = req_valid_i & wd_latch_ff;

    // ************************************************************
    // fault capture, first fault held until reset
    // ************************************************************
    wire [7:0] pos;
    fbr_pos_count #(
        .SLOTS(SLOTS)
    ) u_pos (
        .has_data_i(slot_has_data_i),
        .slot_i(bus_fault_slot_i),
        .pos_o(pos)
    );

    reg [3:0] nxt_code;
    reg [7:0] nxt_arg;
    reg nxt_hit;

    always @* begin
        nxt_hit = 1'b1;
        nxt_code = `FBR_CODE_BUS_DATA;
        nxt_arg = pos;
        if (bus_data_fault_i) begin
            nxt_code = `FBR_CODE_BUS_DATA;
        end else if (bus_init_fault_i) begin
            nxt_code = `FBR_CODE_BUS_INIT;
        end else if (no_bootp_i) begin
            nxt_code = `FBR_CODE_FIELDBUS;
            nxt_arg = `FBR_ARG_NO_BOOTP;
        end else if (not_ident_i) begin
            nxt_code = `FBR_CODE_FIELDBUS;
            nxt_arg = `FBR_ARG_NOT_IDENT;
        end else if (bad_station_hw_identifier_i) begin
            nxt_code = `FBR_CODE_FIELDBUS;
            nxt_arg = `FBR_ARG_BAD_STATION_ID;
        end else if (tcpip_init_err_i) begin
            nxt_code = `FBR_CODE_FIELDBUS;
            nxt_arg = `FBR_ARG_TCPIP_INIT;
        end else if (trap_opcode_i) begin
            nxt_code = `FBR_CODE_TRAP;
            nxt_arg = `FBR_ARG_ILL_OPCODE;
        end else if (trap_stack_ovf_i) begin
            nxt_code = `FBR_CODE_TRAP;
            nxt_arg = `FBR_ARG_STACK_OVF;
        end else if (trap_stack_unf_i) begin
            nxt_code = `FBR_CODE_TRAP;
            nxt_arg = `FBR_ARG_STACK_UNF;
        end else if (trap_nmi_i) begin
            nxt_code = `FBR_CODE_TRAP;
            nxt_arg = `FBR_ARG_NMI;
        end else begin
            nxt_hit = 1'b0;
        end
    end

    // reserved codes 7 and 8 are never loaded
    wire code_ok = (nxt_code != `FBR_CODE_RSVD7) &&
        (nxt_code != `FBR_CODE_RSVD8);

    reg bus_fault_ff;
    always @(posedge clk_i) begin
        if (rst_i) begin
            fault_active_o <= 1'b0;
            fault_code_o <= 4'h0;
            fault_arg_o <= 8'h00;
            bus_fault_ff <= 1'b0;
        end else if (!fault_active_o && nxt_hit && code_ok) begin
            // codes 7 and 8 have no source and are never loaded
            fault_active_o <= 1'b1;
            fault_code_o <= nxt_code;
            fault_arg_o <= nxt_arg;
            bus_fault_ff <= bus_data_fault_i | bus_init_fault_i;
        end
    end

    // ************************************************************
    // node outputs
    // ************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            node_out_o <= {OUT_W{1'b0}};
        end else if (bus_fault_ff) begin
            node_out_o <= stop_state_i;
        end else begin
            node_out_o <= proc_data_i;
        end
    end

    // ************************************************************
    // blink sequencer
    // ************************************************************
    localparam ST_IDLE = 3'h0;
    localparam ST_BURST = 3'h1;
    localparam ST_PAUSE1 = 3'h2;
    localparam ST_CODE = 3'h3;
    localparam ST_PAUSE2 = 3'h4;
    localparam ST_ARG = 3'h5;
    localparam ST_PAUSE3 = 3'h6;
    localparam [7:0] PAUSE_HALVES = 8'h2 * `FBR_PAUSE_PERIODS;

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [7:0] cnt_ff;
    reg [7:0] nxt_cnt;
    reg ph_ff;
    reg nxt_ph;
    reg nxt_lamp;
    wire tick;
    wire restart = (state_ff == ST_IDLE);
    wire fast = (state_ff == ST_BURST);

    fbr_tick #(
        .FAST_HALF(FAST_HALF),
        .SLOW_HALF(SLOW_HALF)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .fast_i(fast),
        .restart_i(restart),
        .tick_o(tick)
    );

    // each flash is an on half then an off half; cnt counts flashes left, or halves left in a pause
    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_ph = ph_ff;
        nxt_lamp = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (fault_active_o) begin
                    nxt_state = ST_BURST;
                    nxt_cnt = `FBR_BURST_FLASHES;
                    nxt_ph = 1'b1;
                end
            end
            ST_BURST, ST_CODE, ST_ARG: begin
                nxt_lamp = ph_ff;
                if (tick) begin
                    nxt_ph = ~ph_ff;
                    if (!ph_ff) begin
                        nxt_cnt = cnt_ff - 8'h01;
                        if (cnt_ff <= 8'h01) begin
                            nxt_ph = 1'b0;
                            nxt_cnt = PAUSE_HALVES;
                            nxt_state = state_ff + 3'h1;
                        end
                    end
                end
            end
            ST_PAUSE1, ST_PAUSE2, ST_PAUSE3: begin
                if (tick) begin
                    nxt_cnt = cnt_ff - 8'h01;
                    if (cnt_ff <= 8'h01) begin
                        nxt_ph = 1'b1;
                        if (state_ff == ST_PAUSE1) begin
                            nxt_state = ST_CODE;
                            nxt_cnt = {4'h0, fault_code_o};
                        end else if (state_ff == ST_PAUSE2) begin
                            nxt_state = ST_ARG;
                            nxt_cnt = fault_arg_o;
                            if (fault_arg_o == 8'h00) begin
                                nxt_ph = 1'b0;
                                nxt_state = ST_PAUSE3;
                                nxt_cnt = PAUSE_HALVES;
                            end
                        end else begin
                            nxt_state = ST_BURST;
                            nxt_cnt = `FBR_BURST_FLASHES;
                        end
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 8'h00;
            ph_ff <= 1'b0;
            bus_lamp_red_o <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            ph_ff <= nxt_ph;
            bus_lamp_red_o <= nxt_lamp;
        end
    end
endmodule
`default_nettype wire

/* File: common/fbr_consts.vh */
/*
 * constants for the fault blink code reporter: fault codes, arguments,
 * blink timing and the fieldbus exception code.
 * assumes a 100 MHz clock on clk_i.
 */
// How it works
// - code 6 arguments: bootp, ident, station id, tcpip
// - codes 7 and 8 never emitted
// - code 9 arguments: opcode, overflow, underflow, nmi
// - position count skips modules without data
// - display opens with ten-per-second start burst
// - pause, then code flashed at one per second
// - second pause, then argument flashed likewise
// - red error lamp steady on fieldbus failure
// - expired watchdog answers requests with exception 4
// - module-bus fault flashes lamp red with code
// - module-bus fault latched as first fault forces outputs to stop state
// - after restart outputs follow current process data
// - code 5 argument is failing module position
`ifndef FBR_CONSTS_VH
`define FBR_CONSTS_VH

// ****************************************************************
// fault codes
// ****************************************************************
`define FBR_CODE_BUS_DATA 4'h4
`define FBR_CODE_BUS_INIT 4'h5
`define FBR_CODE_FIELDBUS 4'h6
`define FBR_CODE_RSVD7 4'h7
`define FBR_CODE_RSVD8 4'h8
`define FBR_CODE_TRAP 4'h9

// ****************************************************************
// arguments for code 6 and code 9
// ****************************************************************
`define FBR_ARG_NO_BOOTP 8'h01
`define FBR_ARG_NOT_IDENT 8'h02
`define FBR_ARG_BAD_STATION_ID 8'h03
`define FBR_ARG_TCPIP_INIT 8'h04
`define FBR_ARG_ILL_OPCODE 8'h01
`define FBR_ARG_STACK_OVF 8'h02
`define FBR_ARG_STACK_UNF 8'h03
`define FBR_ARG_NMI 8'h04

// ****************************************************************
// timing
// ****************************************************************
`define FBR_CLK_HZ 100000000
`define FBR_FAST_HZ 10
`define FBR_SLOW_HZ 1
`define FBR_FAST_HALF (`FBR_CLK_HZ / (2 * `FBR_FAST_HZ))
`define FBR_SLOW_HALF (`FBR_CLK_HZ / (2 * `FBR_SLOW_HZ))
`define FBR_PAUSE_PERIODS 8'h02
`define FBR_BURST_FLASHES 8'h0A

// ****************************************************************
// fieldbus exception
// ****************************************************************
`define FBR_EXC_DEV_FAIL 16'h0004

`endif

/* File: rtl/fbr_pos_count.v */
/*
 * counts data-carrying modules up to a raw slot position.
 * assumes the per-slot data mask is stable while sampled.
 */
`timescale 1ns/1ps
`default_nettype none
module fbr_pos_count #(
    parameter SLOTS = 64
) (
    // slot map
    input wire [SLOTS-1:0] has_data_i,
    input wire [7:0] slot_i,
    // data-module position, one based
    output wire [7:0] pos_o
);
    // ************************************************************
    // count data modules at or below the slot
    // ************************************************************
    wire [7:0] acc [0:SLOTS];
    assign acc[0] = 8'h00;
    genvar g;
    generate
        for (g = 0; g < SLOTS; g = g + 1) begin : g_slot
            assign acc[g+1] = acc[g] +
                {7'h00, has_data_i[g] && (g <= slot_i)};
        end
    endgenerate
    assign pos_o = acc[SLOTS];
endmodule
`default_nettype wire

/* File: rtl/fbr_tick.v */
/*
 * half-period tick generator for the blink sequencer.
 * assumes restart_i comes from the same clock; it holds the count at zero while high.
 */
`timescale 1ns/1ps
`default_nettype none
module fbr_tick #(
    parameter FAST_HALF = 5000000,
    parameter SLOW_HALF = 50000000
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // control
    input wire fast_i,
    input wire restart_i,
    // tick
    output wire tick_o
);
    reg [31:0] cnt_ff;
    wire [31:0] lim = fast_i ? FAST_HALF - 1 : SLOW_HALF - 1;
    assign tick_o = (cnt_ff >= lim);
    always @(posedge clk_i) begin
        if (rst_i || restart_i || tick_o) begin
            cnt_ff <= 32'h0;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
        end
    end
endmodule
`default_nettype wire

/* File: tb/fbr_reporter_sva.sv */
/*
 checker for the fault blink code reporter ports.
 assumes one clock clk_i and synchronous reset rst_i.
*/
`timescale 1ns/1ps
`default_nettype none
module fbr_reporter_sva #(
    parameter OUT_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fieldbus_fail_i,
    input wire logic watchdog_on_i,
    input wire logic watchdog_expired_i,
    input wire logic req_valid_i,
    input wire logic exc_valid_o,
    input wire logic [15:0] exc_code_o,
    input wire logic [OUT_W-1:0] proc_data_i,
    input wire logic [OUT_W-1:0] stop_state_i,
    input wire logic [OUT_W-1:0] node_out_o,
    input wire logic bus_lamp_red_o,
    input wire logic err_lamp_o,
    input wire logic fault_active_o,
    input wire logic [3:0] fault_code_o,
    input wire logic [7:0] fault_arg_o
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_code_legal: assert property (fault_active_o |->
        fault_code_o inside {4'h4, 4'h5, 4'h6, 4'h9})
        else $error("illegal fault code");
    chk_fault_held: assert property (fault_active_o |=>
        fault_active_o && $stable(fault_code_o) && $stable(fault_arg_o))
        else $error("fault report changed");
    chk_lamp_idle: assert property (!fault_active_o |->
        !bus_lamp_red_o) else $error("lamp lit without fault");
    chk_lamp_start: assert property ($rose(fault_active_o) |->
        ##2 bus_lamp_red_o) else $error("display did not start");
    chk_exc_only: assert property (exc_valid_o |->
        req_valid_i && exc_code_o == 16'h0004)
        else $error("bad exception answer");
    chk_wd_refuse: assert property (
        (watchdog_on_i && watchdog_expired_i) [*8] ##1 req_valid_i
        |-> exc_valid_o) else $error("request not refused");
    chk_err_on: assert property (fieldbus_fail_i [*7] |->
        err_lamp_o) else $error("error lamp dark");
    chk_err_off: assert property (!fieldbus_fail_i [*7] |->
        !err_lamp_o) else $error("error lamp lit");
    chk_node_stop: assert property (fault_active_o &&
        fault_code_o inside {4'h4, 4'h5} |=>
        node_out_o == $past(stop_state_i))
        else $error("outputs not in stop state");
    chk_node_follow: assert property (
        !fault_active_o ##1 !fault_active_o |->
        node_out_o == $past(proc_data_i))
        else $error("outputs not following data");
endmodule
bind fbr_reporter fbr_reporter_sva #(.OUT_W(OUT_W)) i_fbr_reporter_sva (
    .clk_i(clk_i), .rst_i(rst_i), .fieldbus_fail_i(fieldbus_fail_i),
    .watchdog_on_i(watchdog_on_i),
    .watchdog_expired_i(watchdog_expired_i), .req_valid_i(req_valid_i),
    .exc_valid_o(exc_valid_o), .exc_code_o(exc_code_o),
    .proc_data_i(proc_data_i), .stop_state_i(stop_state_i),
    .node_out_o(node_out_o), .bus_lamp_red_o(bus_lamp_red_o),
    .err_lamp_o(err_lamp_o), .fault_active_o(fault_active_o),
    .fault_code_o(fault_code_o), .fault_arg_o(fault_arg_o));
`default_nettype wire

/* File: tb/fbr_master_model.sv */
/*
 fieldbus master model: issues one request strobe and takes the answer.
 assumes requests are strobes of one clock on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module fbr_master_model (
    // clock
    input wire logic clk_i,
    // request and answer
    output logic req_valid_o,
    input wire logic exc_valid_i,
    input wire logic [15:0] exc_code_i
);
    initial req_valid_o = 1'b0;
    // ****************************************
    // one request, answer taken at its edge
    // ****************************************
    task automatic request(output logic v, output logic [15:0] c);
        @(negedge clk_i) req_valid_o = 1'b1;
        @(posedge clk_i);
        v = exc_valid_i;
        c = exc_code_i;
        @(negedge clk_i) req_valid_o = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
/*
 self-checking bench for the fault blink code reporter.
 assumes short blink halves of 2 and 4 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i = 0, rst_i = 1, bdf = 0, bif = 0, fbf = 0, wdo = 0;
    logic wde = 0, lamp, err, act, v;
    logic [7:0] slot = 8'h00, f = 8'h00, arg;
    logic [15:0] map = 16'h0000, proc = 16'h0000, stop = 16'h0000;
    logic [15:0] exc_c, node, c;
    logic [3:0] code;
    wire logic req, exc_v;
    int errors = 0, n_compared = 0, n;
    initial forever #5 clk_i = ~clk_i;
    fbr_reporter #(.SLOTS(16), .FAST_HALF(2), .SLOW_HALF(4))
        i_fbr_reporter (.clk_i(clk_i), .rst_i(rst_i),
        .bus_data_fault_i(bdf), .bus_init_fault_i(bif),
        .bus_fault_slot_i(slot), .slot_has_data_i(map),
        .no_bootp_i(f[0]), .not_ident_i(f[1]),
        .bad_station_hw_identifier_i(f[2]), .tcpip_init_err_i(f[3]),
        .trap_opcode_i(f[4]), .trap_stack_ovf_i(f[5]),
        .trap_stack_unf_i(f[6]), .trap_nmi_i(f[7]),
        .fieldbus_fail_i(fbf), .watchdog_on_i(wdo),
        .watchdog_expired_i(wde), .req_valid_i(req),
        .exc_valid_o(exc_v), .exc_code_o(exc_c), .proc_data_i(proc),
        .stop_state_i(stop), .node_out_o(node), .bus_lamp_red_o(lamp),
        .err_lamp_o(err), .fault_active_o(act), .fault_code_o(code),
        .fault_arg_o(arg));
    fbr_master_model i_fbr_master_model (.clk_i(clk_i),
        .req_valid_o(req), .exc_valid_i(exc_v), .exc_code_i(exc_c));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic give_verdict;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic do_reset;
        @(negedge clk_i) rst_i = 1;
        wdo = 0;
        wde = 0;
        repeat (3) @(negedge clk_i);
        rst_i = 0;
    endtask
    function automatic int pos(input logic [15:0] m, input int s);
        pos = 0;
        for (int j = 0; j <= s; j++) pos += m[j];
    endfunction
    // counts flashes of one group; a long dark run ends it
    task automatic grp(output int k);
        int t, lo;
        logic p;
        t = 0;
        while (lamp !== 1'b1 && t < 300) begin
            @(negedge clk_i);
            t++;
        end
        if (t >= 300) begin
            errors++;
            give_verdict;
        end
        k = 1;
        lo = 0;
        t = 0;
        while (lo < 12 && t < 400) begin
            p = lamp;
            @(negedge clk_i);
            if (lamp && !p) k++;
            lo = lamp ? 0 : lo + 1;
            t++;
        end
        if (t >= 400) begin
            errors++;
            give_verdict;
        end
    endtask
    task automatic pulse_bus(input logic init, input int s, input int cd);
        int p;
        do_reset;
        p = pos(map, s);
        slot = s[7:0];
        if (init) bif = 1;
        else bdf = 1;
        @(negedge clk_i) {bif, bdf} = 2'b00;
        f = 8'h80;
        @(negedge clk_i) f = 0;
        cmp(act, 1);
        cmp(code, cd);
        cmp(arg, p);
        cmp(node, stop);
        grp(n);
        cmp(n, 10);
        grp(n);
        cmp(n, cd);
        grp(n);
        cmp(n, p ? p : 10);
        grp(n);
        cmp(n, p ? 10 : cd);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic s_bus;
        map = 16'hB6D5;
        proc = 16'h1234;
        stop = 16'hA5C3;
        pulse_bus(0, 7, 4);
        map = 16'h00F2;
        pulse_bus(1, 4, 5);
        map = 16'hFFF0;
        pulse_bus(0, 3, 4);
    endtask
    task automatic s_restart;
        do_reset;
        @(negedge clk_i) proc = 16'h5A3C;
        @(negedge clk_i) cmp(node, 16'h5A3C);
        cmp(lamp, 0);
    endtask
    task automatic s_codes;
        for (int i = 0; i < 9; i++) begin
            do_reset;
            f = (i == 8) ? 8'h81 : 8'h01 << i;
            @(negedge clk_i) f = 0;
            @(negedge clk_i) cmp(code, i < 4 || i == 8 ? 6 : 9);
            cmp(arg, i % 4 + 1);
        end
    endtask
    task automatic s_err;
        int t;
        fbf = 1;
        t = 0;
        while (err !== 1'b1 && t < 10) begin
            @(negedge clk_i);
            t++;
        end
        if (t >= 10) begin
            errors++;
            give_verdict;
        end
        repeat (20) @(negedge clk_i);
        cmp(err, 1);
        fbf = 0;
        repeat (8) @(negedge clk_i);
        cmp(err, 0);
    endtask
    task automatic s_wd;
        do_reset;
        wde = 1;
        repeat (10) @(negedge clk_i);
        i_fbr_master_model.request(v, c);
        cmp(v, 0);
        cmp(c, 16'h0000);
        wdo = 1;
        repeat (10) @(negedge clk_i);
        i_fbr_master_model.request(v, c);
        cmp(v, 1);
        cmp(c, 16'h0004);
        i_fbr_master_model.request(v, c);
        cmp(v, 1);
    endtask
    initial begin
        repeat (20) @(negedge clk_i);
        rst_i = 0;
        s_bus;
        s_restart;
        s_codes;
        s_err;
        s_wd;
        give_verdict;
    end
endmodule
`default_nettype wire
